/* design/pcd_pkg.sv */
// Constants and types for the port conversion data register bank
package pcd_pkg;

    localparam int unsigned NUM_PORTS  = 12;
    localparam int unsigned DATA_W     = 12;
    localparam int unsigned REG_W      = 16;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned MODE_W     = 4;
    localparam int unsigned RANGE_W    = 3;
    localparam int unsigned PORT_IDX_W = 4;

    // Register map
    localparam logic [ADDR_W-1:0] ADC_RESULT_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] DAC_CODE_BASE   = 8'h60;

    // Field layout and reset values
    localparam int unsigned       DATA_LSB       = 0;
    localparam logic [DATA_W-1:0] ADC_RESULT_RST = 12'h000;
    localparam logic [DATA_W-1:0] DAC_CODE_RST   = 12'h000;
    localparam logic [REG_W-1:0]  RDATA_RST      = 16'h0000;
    localparam logic [DATA_W-1:0] ZERO_CODE      = 12'h000;

    // Offset binary to two's complement: invert the sign bit
    localparam logic [DATA_W-1:0] TWOS_FLIP = 12'h800;

    // Low input range codes that need the output clip
    localparam logic [RANGE_W-1:0] RANGE_LOW_A = 3'b100;
    localparam logic [RANGE_W-1:0] RANGE_LOW_B = 3'b110;

    // Highest code keeping the port within the safe window
    localparam logic [DATA_W-1:0] DAC_CLIP_MAX_RST = 12'h7ff;

    typedef enum logic [MODE_W-1:0] {
        PCD_MODE_HIZ      = 4'h0,
        PCD_MODE_DAC_MON  = 4'h6,
        PCD_MODE_SE_ADC   = 4'h7,
        PCD_MODE_DIFF_POS = 4'h8,
        PCD_MODE_DIFF_NEG = 4'h9,
        PCD_MODE_PSEUDO   = 4'ha
    } pcd_mode_t;

endpackage : pcd_pkg

/* design/pcd_adc_enc.sv */
// Per-port result encoder chosen by the port's functional mode
`timescale 1ns/1ps
module pcd_adc_enc
    import pcd_pkg::*;
(
    input  wire logic [pcd_pkg::MODE_W-1:0] mode_in,
    input  wire logic [pcd_pkg::DATA_W-1:0] raw_in,
    output logic      [pcd_pkg::DATA_W-1:0] code_out,
    output logic                            load_out,
    output logic                            zero_out
);
    wire logic is_single;
    wire logic is_pos;
    wire logic is_neg;

    assign is_single = (mode_in == PCD_MODE_DAC_MON) || (mode_in == PCD_MODE_SE_ADC);
    assign is_pos    = (mode_in == PCD_MODE_DIFF_POS);
    // Negative inputs may be shared by several positive ports
    assign is_neg    = (mode_in == PCD_MODE_DIFF_NEG) || (mode_in == PCD_MODE_PSEUDO);

    assign code_out  = is_pos ? (raw_in ^ TWOS_FLIP) : raw_in;
    assign load_out  = is_single || is_pos;
    assign zero_out  = is_neg;

endmodule : pcd_adc_enc

/* design/pcd_regs.sv */
// Top: ADC result and DAC code register bank for twelve ports
//
// Function
// - Twelve-bit conversion result per port, low field
// - Modes 6 and 7 give straight binary
// - Mode 8 result in two's complement
// - Modes 9 and 10 always read zero
// - Twelve read/write DAC code registers, ports 0-11
// - DAC codes are unsigned straight binary
// - One result register per port 0-11
// - Mode 10 low range clips DAC code
// - One negative port serves many positives
`timescale 1ns/1ps
module pcd_regs
    import pcd_pkg::*;
#(
    parameter int unsigned NPORT = NUM_PORTS
)
(
    input  wire logic                                           clk_in,
    input  wire logic                                           rstn_in,
    // Register access from the serial interface decoder
    input  wire logic [pcd_pkg::ADDR_W-1:0]                     reg_addr_in,
    input  wire logic                                           reg_wr_in,
    input  wire logic [pcd_pkg::REG_W-1:0]                      reg_wdata_in,
    input  wire logic                                           reg_rd_in,
    output logic      [pcd_pkg::REG_W-1:0]                      reg_rdata_out,
    output logic                                                reg_rvalid_out,
    // Port configuration from the mode registers
    input  wire logic [NPORT-1:0][pcd_pkg::MODE_W-1:0]          port_mode_in,
    input  wire logic [NPORT-1:0][pcd_pkg::RANGE_W-1:0]         port_range_in,
    input  wire logic [pcd_pkg::DATA_W-1:0]                     dac_clip_max_in,
    // Converter sample delivery
    input  wire logic                                           adc_valid_in,
    input  wire logic [pcd_pkg::PORT_IDX_W-1:0]                 adc_port_in,
    input  wire logic [pcd_pkg::DATA_W-1:0]                     adc_raw_in,
    // Codes to the port output converters
    output logic      [NPORT-1:0][pcd_pkg::DATA_W-1:0]          dac_code_out
);
    import pcd_pkg::*;

    // Address decode shared by read and write paths
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] off;
        off      = addr - base;
        addr_hit = (addr >= base) && (off < ADDR_W'(NPORT));
    endfunction : addr_hit

    function automatic logic [PORT_IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] addr,
                                                       input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] off;
        off      = addr - base;
        addr_idx = off[PORT_IDX_W-1:0];
    endfunction : addr_idx

    // Place a data field in a register word; upper bits stay zero
    function automatic logic [REG_W-1:0] to_word(input logic [DATA_W-1:0] field);
        logic [REG_W-1:0] word;
        word                     = RDATA_RST;
        word[DATA_LSB +: DATA_W] = field;
        to_word                  = word;
    endfunction : to_word

    // Input range codes that limit the driven code
    function automatic logic is_low_range(input logic [RANGE_W-1:0] rng);
        is_low_range = (rng == RANGE_LOW_A) || (rng == RANGE_LOW_B);
    endfunction : is_low_range

    logic [NPORT-1:0][DATA_W-1:0] adc_q;
    logic [NPORT-1:0][DATA_W-1:0] adc_d;
    logic [NPORT-1:0][DATA_W-1:0] dac_q;
    logic [NPORT-1:0][DATA_W-1:0] dac_d;
    logic [NPORT-1:0][DATA_W-1:0] dac_out_d;
    logic [NPORT-1:0][DATA_W-1:0] adc_view;
    logic [NPORT-1:0]             force_zero;

    wire logic                  adc_rd_hit;
    wire logic                  dac_rd_hit;
    wire logic                  dac_wr_hit;
    wire logic [PORT_IDX_W-1:0] adc_rd_idx;
    wire logic [PORT_IDX_W-1:0] dac_rd_idx;
    wire logic [PORT_IDX_W-1:0] dac_wr_idx;
    wire logic [REG_W-1:0]      rdata_d;
    wire logic [REG_W-1:0]      adc_sel;
    wire logic [REG_W-1:0]      dac_sel;
    wire logic [DATA_W-1:0]     wr_field;
    wire logic                  sample_in_range;

    // Result words; named views assume the full twelve ports
    wire logic [REG_W-1:0]      adc_result_port0;
    wire logic [REG_W-1:0]      adc_result_port1;
    wire logic [REG_W-1:0]      adc_result_port2;
    wire logic [REG_W-1:0]      adc_result_port3;
    wire logic [REG_W-1:0]      adc_result_port4;
    wire logic [REG_W-1:0]      adc_result_port5;
    wire logic [REG_W-1:0]      adc_result_port6;
    wire logic [REG_W-1:0]      adc_result_port7;
    wire logic [REG_W-1:0]      adc_result_port8;
    wire logic [REG_W-1:0]      adc_result_port9;
    wire logic [REG_W-1:0]      adc_result_port10;
    wire logic [REG_W-1:0]      adc_result_port11;

    // Code words as stored, before any clip
    wire logic [REG_W-1:0]      dac_code_port0;
    wire logic [REG_W-1:0]      dac_code_port1;
    wire logic [REG_W-1:0]      dac_code_port2;
    wire logic [REG_W-1:0]      dac_code_port3;
    wire logic [REG_W-1:0]      dac_code_port4;
    wire logic [REG_W-1:0]      dac_code_port5;
    wire logic [REG_W-1:0]      dac_code_port6;
    wire logic [REG_W-1:0]      dac_code_port7;
    wire logic [REG_W-1:0]      dac_code_port8;
    wire logic [REG_W-1:0]      dac_code_port9;
    wire logic [REG_W-1:0]      dac_code_port10;
    wire logic [REG_W-1:0]      dac_code_port11;

    assign adc_rd_hit = addr_hit(reg_addr_in, ADC_RESULT_BASE);
    assign dac_rd_hit = addr_hit(reg_addr_in, DAC_CODE_BASE);
    // Result registers have no write path at all
    assign dac_wr_hit = reg_wr_in && dac_rd_hit;
    assign adc_rd_idx = addr_idx(reg_addr_in, ADC_RESULT_BASE);
    assign dac_rd_idx = addr_idx(reg_addr_in, DAC_CODE_BASE);
    assign dac_wr_idx = dac_rd_idx;

    // Sample for a port index past the last port is dropped
    assign sample_in_range = (adc_port_in < PORT_IDX_W'(NPORT));

    // Bits above the field are dropped on write
    assign wr_field = reg_wdata_in[DATA_LSB +: DATA_W];

    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi++)
        begin : g_port
            wire logic [DATA_W-1:0] enc_code;
            wire logic              enc_load;
            wire logic              sample_hit;
            wire logic              wr_sel;
            wire logic              range_low;
            wire logic              clip_on;

            pcd_adc_enc u_enc (
                .mode_in  (port_mode_in[gi]),
                .raw_in   (adc_raw_in),
                .code_out (enc_code),
                .load_out (enc_load),
                .zero_out (force_zero[gi])
            );

            // Each sample lands only in its own port's register
            assign sample_hit = adc_valid_in && sample_in_range &&
                                (adc_port_in == PORT_IDX_W'(gi)) && enc_load;

            assign adc_d[gi] = force_zero[gi] ? ZERO_CODE :
                               sample_hit     ? enc_code  : adc_q[gi];
            // Read view masks too, so a mode change shows zero at once
            assign adc_view[gi] = force_zero[gi] ? ZERO_CODE : adc_q[gi];

            // Stored code is unsigned; host writes it as such
            assign wr_sel    = dac_wr_hit && (dac_wr_idx == PORT_IDX_W'(gi));
            assign dac_d[gi] = wr_sel ? wr_field : dac_q[gi];

            // Register keeps the written code; only the drive is limited
            assign range_low = is_low_range(port_range_in[gi]);
            assign clip_on   = (port_mode_in[gi] == PCD_MODE_PSEUDO) && range_low;
            assign dac_out_d[gi] = (clip_on && (dac_q[gi] > dac_clip_max_in))
                                 ? dac_clip_max_in : dac_q[gi];

            // Separate registers keep each always_ff short
            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    adc_q[gi] <= ADC_RESULT_RST;
                end
                else
                begin
                    adc_q[gi] <= adc_d[gi];
                end
            end

            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    dac_q[gi] <= DAC_CODE_RST;
                end
                else
                begin
                    dac_q[gi] <= dac_d[gi];
                end
            end

            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    dac_code_out[gi] <= DAC_CODE_RST;
                end
                else
                begin
                    dac_code_out[gi] <= dac_out_d[gi];
                end
            end
        end
    endgenerate

    // Result views carry the zero mask of negative ports
    assign adc_result_port0  = to_word(adc_view[0]);
    assign adc_result_port1  = to_word(adc_view[1]);
    assign adc_result_port2  = to_word(adc_view[2]);
    assign adc_result_port3  = to_word(adc_view[3]);
    assign adc_result_port4  = to_word(adc_view[4]);
    assign adc_result_port5  = to_word(adc_view[5]);
    assign adc_result_port6  = to_word(adc_view[6]);
    assign adc_result_port7  = to_word(adc_view[7]);
    assign adc_result_port8  = to_word(adc_view[8]);
    assign adc_result_port9  = to_word(adc_view[9]);
    assign adc_result_port10 = to_word(adc_view[10]);
    assign adc_result_port11 = to_word(adc_view[11]);

    // Readback shows the written code, not the clipped drive
    assign dac_code_port0    = to_word(dac_q[0]);
    assign dac_code_port1    = to_word(dac_q[1]);
    assign dac_code_port2    = to_word(dac_q[2]);
    assign dac_code_port3    = to_word(dac_q[3]);
    assign dac_code_port4    = to_word(dac_q[4]);
    assign dac_code_port5    = to_word(dac_q[5]);
    assign dac_code_port6    = to_word(dac_q[6]);
    assign dac_code_port7    = to_word(dac_q[7]);
    assign dac_code_port8    = to_word(dac_q[8]);
    assign dac_code_port9    = to_word(dac_q[9]);
    assign dac_code_port10   = to_word(dac_q[10]);
    assign dac_code_port11   = to_word(dac_q[11]);

    // Per-kind selection by port index
    assign adc_sel = (adc_rd_idx == 4'h0) ? adc_result_port0  :
                     (adc_rd_idx == 4'h1) ? adc_result_port1  :
                     (adc_rd_idx == 4'h2) ? adc_result_port2  :
                     (adc_rd_idx == 4'h3) ? adc_result_port3  :
                     (adc_rd_idx == 4'h4) ? adc_result_port4  :
                     (adc_rd_idx == 4'h5) ? adc_result_port5  :
                     (adc_rd_idx == 4'h6) ? adc_result_port6  :
                     (adc_rd_idx == 4'h7) ? adc_result_port7  :
                     (adc_rd_idx == 4'h8) ? adc_result_port8  :
                     (adc_rd_idx == 4'h9) ? adc_result_port9  :
                     (adc_rd_idx == 4'ha) ? adc_result_port10 :
                     (adc_rd_idx == 4'hb) ? adc_result_port11 :
                                            RDATA_RST;

    assign dac_sel = (dac_rd_idx == 4'h0) ? dac_code_port0  :
                     (dac_rd_idx == 4'h1) ? dac_code_port1  :
                     (dac_rd_idx == 4'h2) ? dac_code_port2  :
                     (dac_rd_idx == 4'h3) ? dac_code_port3  :
                     (dac_rd_idx == 4'h4) ? dac_code_port4  :
                     (dac_rd_idx == 4'h5) ? dac_code_port5  :
                     (dac_rd_idx == 4'h6) ? dac_code_port6  :
                     (dac_rd_idx == 4'h7) ? dac_code_port7  :
                     (dac_rd_idx == 4'h8) ? dac_code_port8  :
                     (dac_rd_idx == 4'h9) ? dac_code_port9  :
                     (dac_rd_idx == 4'ha) ? dac_code_port10 :
                     (dac_rd_idx == 4'hb) ? dac_code_port11 :
                                            RDATA_RST;

    // Upper bits zero; unmapped addresses read as zero
    assign rdata_d = adc_rd_hit ? adc_sel :
                     dac_rd_hit ? dac_sel :
                                  RDATA_RST;

    // Strobe echo, one cycle later, stands as long as the strobe does
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
        end
    end

    // Read word holds until the next read
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            reg_rdata_out <= RDATA_RST;
        end
        else if (reg_rd_in)
        begin
            reg_rdata_out <= rdata_d;
        end
    end

endmodule : pcd_regs

/* testbench/pcd_regs_asserts.sv */
// Assertion checker for the port conversion data register bank
`timescale 1ns/1ps
module pcd_regs_chk
    import pcd_pkg::*;
#(
    parameter int unsigned NPORT = NUM_PORTS
)
(
    input  wire logic                          clk_in,
    input  wire logic                          rstn_in,
    input  wire logic [ADDR_W-1:0]             reg_addr_in,
    input  wire logic                          reg_wr_in,
    input  wire logic [REG_W-1:0]              reg_wdata_in,
    input  wire logic                          reg_rd_in,
    input  wire logic [REG_W-1:0]              reg_rdata_out,
    input  wire logic                          reg_rvalid_out,
    input  wire logic [NPORT-1:0][MODE_W-1:0]  port_mode_in,
    input  wire logic [NPORT-1:0][RANGE_W-1:0] port_range_in,
    input  wire logic [DATA_W-1:0]             dac_clip_max_in,
    input  wire logic                          adc_valid_in,
    input  wire logic [PORT_IDX_W-1:0]         adc_port_in,
    input  wire logic [DATA_W-1:0]             adc_raw_in,
    input  wire logic [NPORT-1:0][DATA_W-1:0]  dac_code_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    wire [3:0] ai = reg_addr_in[3:0];
    wire dac_wr = reg_wr_in && reg_addr_in[7:4] == 4'h6 && ai < 4'hc;
    wire res_rd = reg_rd_in && reg_addr_in[7:4] == 4'h4 && ai < 4'hc;
    // A sample landing with the read would race it, so it is excluded
    sequence s_smp_rd;
        adc_valid_in ##1 reg_rd_in && reg_addr_in == {4'h4, $past(adc_port_in)}
            && !adc_valid_in && $stable(port_mode_in);
    endsequence
    property p_rvalid; reg_rd_in |=> reg_rvalid_out; endproperty
    a_rvalid: assert property (p_rvalid) else $error("no read answer");
    property p_rvalid_low; !reg_rd_in |=> !reg_rvalid_out; endproperty
    a_rvalid_low: assert property (p_rvalid_low) else $error("read answer without strobe");
    property p_upper; reg_rvalid_out |-> reg_rdata_out[15:12] == 4'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_dac_rb; dac_wr ##1 reg_rd_in && $stable(reg_addr_in)
        |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 16'h0fff); endproperty
    a_dac_rb: assert property (p_dac_rb) else $error("code readback wrong");
    property p_neg; res_rd && port_mode_in[ai] inside {4'h9, 4'ha} |=> reg_rdata_out == 16'h0; endproperty
    a_neg: assert property (p_neg) else $error("negative port not zero");
    property p_se; port_mode_in[adc_port_in] inside {4'h6, 4'h7} ##0 s_smp_rd
        |=> reg_rdata_out == {4'h0, $past(adc_raw_in, 2)}; endproperty
    a_se: assert property (p_se) else $error("single ended result wrong");
    property p_pos; port_mode_in[adc_port_in] == 4'h8 ##0 s_smp_rd
        |=> reg_rdata_out == {4'h0, $past(adc_raw_in, 2) ^ 12'h800}; endproperty
    a_pos: assert property (p_pos) else $error("differential result wrong");
    property p_dac_out; dac_wr && port_mode_in[ai] != 4'ha ##1 !reg_wr_in && $stable(port_mode_in)
        |=> dac_code_out[$past(ai, 2)] == $past(reg_wdata_in[11:0], 2); endproperty
    a_dac_out: assert property (p_dac_out) else $error("driven code wrong");
    property p_clip; port_mode_in[5] == 4'ha && port_range_in[5] inside {3'b100, 3'b110}
        && $stable(port_mode_in) && $stable(port_range_in) && $stable(dac_clip_max_in)
        |-> dac_code_out[5] <= dac_clip_max_in; endproperty
    a_clip: assert property (p_clip) else $error("code not clipped");
    c_smp: cover property (s_smp_rd);
    c_wr_rd: cover property (dac_wr ##1 reg_rd_in);
    c_neg: cover property (res_rd && port_mode_in[ai] == 4'ha);
endmodule : pcd_regs_chk
bind pcd_regs pcd_regs_chk #(
    .NPORT(NPORT)
) u_chk (
    .clk_in          (clk_in),
    .rstn_in         (rstn_in),
    .reg_addr_in     (reg_addr_in),
    .reg_wr_in       (reg_wr_in),
    .reg_wdata_in    (reg_wdata_in),
    .reg_rd_in       (reg_rd_in),
    .reg_rdata_out   (reg_rdata_out),
    .reg_rvalid_out  (reg_rvalid_out),
    .port_mode_in    (port_mode_in),
    .port_range_in   (port_range_in),
    .dac_clip_max_in (dac_clip_max_in),
    .adc_valid_in    (adc_valid_in),
    .adc_port_in     (adc_port_in),
    .adc_raw_in      (adc_raw_in),
    .dac_code_out    (dac_code_out)
);

/* testbench/pcd_host.sv */
// Host model: register strobes from the falling clock edge
`timescale 1ns/1ps
module pcd_host
(
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    output logic [7:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [15:0] wdata_out
);
    initial {addr_out, wr_out, rd_out, wdata_out} = '0;
    // Codes written are plain unsigned binary
    task automatic op(input logic [7:0] a, input logic w, r, input logic [15:0] d);
        @(negedge clk_in);
        {addr_out, wr_out, rd_out, wdata_out} = {a, w, r, d};
    endtask : op
    // Address moved away after the strobe so a stale decode shows
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        op(a, 1'b0, 1'b1, 16'h0);
        op(~a, 1'b0, 1'b0, 16'h0);
        d = rdata_in;
    endtask : rd
endmodule : pcd_host

/* testbench/tb_top.sv */
// Self-checking testbench for the port conversion data register bank
`timescale 1ns/1ps
module tb_top;
    import pcd_pkg::*;
    logic clk_in = 1'b0, rstn_in, w, r, av, rv;
    logic [7:0] a;
    logic [15:0] wd, rdat, d;
    logic [3:0] ap;
    logic [11:0] clip, ar;
    logic [11:0][3:0] md = {4'h7, 4'h8, 4'h7, 4'h7, 4'h7, 4'h8, 4'ha, 4'ha, 4'h9, 4'h8, 4'h6, 4'h7};
    logic [11:0][2:0] rg = 36'h000026000;
    logic [11:0][11:0] dco;
    int fail_count = 0, checks = 0;
    pcd_regs u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(a), .reg_wr_in(w), .reg_wdata_in(wd),
        .reg_rd_in(r), .reg_rdata_out(rdat), .reg_rvalid_out(rv), .port_mode_in(md), .port_range_in(rg),
        .dac_clip_max_in(clip), .adc_valid_in(av), .adc_port_in(ap), .adc_raw_in(ar), .dac_code_out(dco));
    pcd_host u_host (.clk_in(clk_in), .rdata_in(rdat), .addr_out(a), .wr_out(w), .rd_out(r), .wdata_out(wd));
    function automatic logic [15:0] er(input logic [3:0] m, input logic [11:0] x);
        return m == 4'h8 ? {4'h0, x ^ 12'h800} : m inside {4'h6, 4'h7} ? {4'h0, x} : 16'h0;
    endfunction : er
    task automatic chk(input logic [15:0] g, e);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic chk_flag(input logic g, e);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_flag
    task automatic final_report;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    initial forever #5 clk_in = ~clk_in;
    initial
    begin
        repeat (1000) @(posedge clk_in);
        fail_count++;
        final_report;
    end
    initial
    begin
        {rstn_in, av, ap, ar, clip} = {1'b0, 1'b0, 4'h0, 12'h0, 12'h7ff};
        repeat (5) @(posedge clk_in);
        @(negedge clk_in) rstn_in = 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            @(negedge clk_in) {av, ap, ar} = {1'b1, 4'(i), 12'h900 + 12'(i)};
            fork
                u_host.rd(8'h40 + 8'(i), d);
                @(negedge clk_in) av = 1'b0;
            join
            chk(d, er(md[i], 12'h900 + 12'(i)));
            chk_flag(rv, 1'b1);
        end
        for (int i = 0; i < 12; i++)
        begin
            u_host.rd(8'h60 + 8'(i), d);
            chk(d, 16'h0);
            u_host.op(8'h60 + 8'(i), 1'b1, 1'b0, 16'hffa0 + 16'(i));
            chk_flag(rv, 1'b0);
            u_host.rd(8'h60 + 8'(i), d);
            chk(d, 16'h0fa0 + 16'(i));
        end
        u_host.op(8'h42, 1'b1, 1'b0, 16'hffff);
        u_host.rd(8'h42, d);
        chk(d, er(md[2], 12'h902));
        @(negedge clk_in) md[2] = 4'h9;
        u_host.rd(8'h42, d);
        chk(d, 16'h0);
        u_host.rd(8'h4c, d);
        chk(d, 16'h0);
        for (int i = 0; i < 12; i++)
            chk({4'h0, dco[i]}, i == 4 || i == 5 ? 16'h07ff : 16'h0fa0 + 16'(i));
        final_report;
    end
endmodule : tb_top
